// file: hw/pie_pkg.sv
// pie_pkg: register map, field positions and reset values of the
// peripheral interrupt enable banks for timers and capture/compare units.
// assumes a 32-bit classic wishbone slave with word-aligned registers.

package pie_pkg;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [7:0] PIE_OFS_TIMERS     = 8'h00;
   localparam logic [7:0] PIE_OFS_CAPCMP     = 8'h04;
   localparam logic [7:0] PIE_OFS_FLAGS_TMR  = 8'h08;
   localparam logic [7:0] PIE_OFS_FLAGS_CC   = 8'h0c;
   localparam logic [7:0] PIE_OFS_CTRL       = 8'h10;
   localparam logic [7:0] PIE_OFS_STATUS     = 8'h14;

   // ----------------------------------------------------------------
   // reset values and fixed masks
   // ----------------------------------------------------------------
   localparam logic [7:0] PIE_RST_TIMERS     = 8'h00;
   localparam logic [7:0] PIE_RST_CAPCMP     = 8'h00;
   localparam logic [7:0] PIE_RST_FLAGS      = 8'h00;
   localparam logic [7:0] PIE_TIMERS_IMPL    = 8'h7f;
   localparam logic [7:0] PIE_CAPCMP_IMPL    = 8'hff;
   localparam logic [7:0] PIE_CAPCMP_LARGE   = 8'h8c;

   // ----------------------------------------------------------------
   // timer bank fields
   // ----------------------------------------------------------------
   localparam int PIE_TMR_UNUSED_BIT       = 7;
   localparam int PIE_TIMER_EIGHT_MATCH    = 6;
   localparam int PIE_TIMER_FIVE_GATE      = 5;
   localparam int PIE_TIMER_FIVE_EVENT     = 4;
   localparam int PIE_TIMER_THREE_GATE     = 3;
   localparam int PIE_TIMER_THREE_EVENT    = 2;
   localparam int PIE_TIMER_SIX_MATCH      = 1;
   localparam int PIE_TIMER_FOUR_MATCH     = 0;

   // ----------------------------------------------------------------
   // capture/compare bank fields
   // ----------------------------------------------------------------
   localparam int PIE_CAPCMP_EIGHT         = 7;
   localparam int PIE_CAPCMP_SEVEN         = 6;
   localparam int PIE_OUTGEN_FOUR_SHUTDOWN = 5;
   localparam int PIE_OUTGEN_THREE_SHUTDOWN = 4;
   localparam int PIE_COMPARATOR_EIGHT     = 3;
   localparam int PIE_COMPARATOR_SEVEN     = 2;
   localparam int PIE_COMPARATOR_SIX       = 1;
   localparam int PIE_COMPARATOR_FIVE      = 0;

   // ----------------------------------------------------------------
   // control / status fields
   // ----------------------------------------------------------------
   localparam int PIE_CTRL_PERIPH_EN       = 0;
   localparam int PIE_STAT_REQUEST         = 0;

endpackage : pie_pkg

// file: hw/pie_flag_bank.sv
// pie_flag_bank: eight sticky request flags and their enable gating.
// assumes event pulses on clk_i; software clears by write-one-to-clear.
`timescale 1ns/100ps

module pie_flag_bank
   import pie_pkg::*;
#(
   parameter logic [7:0] IMPL = 8'hff
) (
   // clock and reset
   input  wire logic       clk_i,
   input  wire logic       rst_i,
   // events and software clear
   input  wire logic [7:0] event_i,
   input  wire logic [7:0] clear_i,
   input  wire logic [7:0] enable_i,
   // state
   output logic      [7:0] flag_o,
   output logic      [7:0] gated_o
);

   logic [7:0] flag_q;

   // ----------------------------------------------------------------
   // sticky flags, set wins over clear
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flag_q <= PIE_RST_FLAGS;
      end else begin
         flag_q <= ((flag_q & ~clear_i) | event_i) & IMPL;
      end
   end

   assign flag_o  = flag_q;
   assign gated_o = flag_q & enable_i & IMPL;

endmodule : pie_flag_bank

// file: hw/pie_wb_slave.sv
// pie_wb_slave: classic wishbone handshake, one wait state, single beat.
// assumes the master holds its request until ack.
`timescale 1ns/100ps

module pie_wb_slave (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_i,
   // bus handshake
   input  wire logic cyc_i,
   input  wire logic stb_i,
   output logic      ack_o,
   // access strobe toward the register file
   output logic      access_o
);

   logic ack_q;

   // ack one cycle after request, dropped the cycle after
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= cyc_i & stb_i & ~ack_q;
      end
   end

   assign ack_o    = ack_q;
   assign access_o = cyc_i & stb_i & ~ack_q;

endmodule : pie_wb_slave

// file: hw/pie_irq_enable.sv
// pie_irq_enable: two enable banks gating timer and capture/compare
// interrupt sources into one combined peripheral request.
// assumes single-cycle event pulses from sources on clk_i.
`timescale 1ns/100ps

module pie_irq_enable
   import pie_pkg::*;
#(
   parameter bit LARGE_VARIANT = 1'b1
) (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wishbone slave
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   output logic      [31:0] dat_o,
   output logic             ack_o,
   // timer event pulses
   input  wire logic        timer_eight_match_i,
   input  wire logic        timer_five_gate_i,
   input  wire logic        timer_five_event_i,
   input  wire logic        timer_three_gate_i,
   input  wire logic        timer_three_event_i,
   input  wire logic        timer_six_match_i,
   input  wire logic        timer_four_match_i,
   // capture/compare, output generator and comparator event pulses
   input  wire logic        capcmp_eight_i,
   input  wire logic        capcmp_seven_i,
   input  wire logic        outgen_four_shutdown_i,
   input  wire logic        outgen_three_shutdown_i,
   input  wire logic        comparator_eight_i,
   input  wire logic        comparator_seven_i,
   input  wire logic        comparator_six_i,
   input  wire logic        comparator_five_i,
   // combined request toward the core
   output logic             periph_irq_o
);

   // ----------------------------------------------------------------
   // implemented bit masks
   // ----------------------------------------------------------------
   localparam logic [7:0] TMR_MASK = PIE_TIMERS_IMPL;
   localparam logic [7:0] CC_MASK  = LARGE_VARIANT ? PIE_CAPCMP_IMPL
                                     : (PIE_CAPCMP_IMPL & ~PIE_CAPCMP_LARGE);

   logic [7:0] periph_irq_enable_timers_q;
   logic [7:0] periph_irq_enable_capture_cmp_q;
   logic       peripheral_master_en_q;
   logic       irq_q;
   logic       access;
   logic       wr;
   logic [7:0] wbyte;
   logic [7:0] tmr_events;
   logic [7:0] cc_events;
   logic [7:0] tmr_flags;
   logic [7:0] cc_flags;
   logic [7:0] tmr_gated;
   logic [7:0] cc_gated;
   logic [7:0] tmr_clear;
   logic [7:0] cc_clear;
   logic [31:0] rdata;

   // address match helper
   function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   // ----------------------------------------------------------------
   // bus handshake
   // ----------------------------------------------------------------
   pie_wb_slave u_wb (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .cyc_i    (cyc_i),
      .stb_i    (stb_i),
      .ack_o    (ack_o),
      .access_o (access)
   );

   assign wr    = access & we_i & sel_i[0];
   assign wbyte = dat_i[7:0];

   // ----------------------------------------------------------------
   // enable registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         periph_irq_enable_timers_q <= PIE_RST_TIMERS;
      end else if (wr && hit(adr_i, PIE_OFS_TIMERS)) begin
         periph_irq_enable_timers_q <= wbyte & TMR_MASK;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         periph_irq_enable_capture_cmp_q <= PIE_RST_CAPCMP;
      end else if (wr && hit(adr_i, PIE_OFS_CAPCMP)) begin
         periph_irq_enable_capture_cmp_q <= wbyte & CC_MASK;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         peripheral_master_en_q <= 1'b0;
      end else if (wr && hit(adr_i, PIE_OFS_CTRL)) begin
         peripheral_master_en_q <= wbyte[PIE_CTRL_PERIPH_EN];
      end
   end

   // ----------------------------------------------------------------
   // source placement
   // ----------------------------------------------------------------
   always_comb begin
      tmr_events = 8'h00;
      tmr_events[PIE_TIMER_EIGHT_MATCH] = timer_eight_match_i;
      tmr_events[PIE_TIMER_FIVE_GATE]   = timer_five_gate_i;
      tmr_events[PIE_TIMER_FIVE_EVENT]  = timer_five_event_i;
      tmr_events[PIE_TIMER_THREE_GATE]  = timer_three_gate_i;
      tmr_events[PIE_TIMER_THREE_EVENT] = timer_three_event_i;
      tmr_events[PIE_TIMER_SIX_MATCH]   = timer_six_match_i;
      tmr_events[PIE_TIMER_FOUR_MATCH]  = timer_four_match_i;
   end

   always_comb begin
      cc_events = 8'h00;
      cc_events[PIE_CAPCMP_EIGHT]          = capcmp_eight_i;
      cc_events[PIE_CAPCMP_SEVEN]          = capcmp_seven_i;
      cc_events[PIE_OUTGEN_FOUR_SHUTDOWN]  = outgen_four_shutdown_i;
      cc_events[PIE_OUTGEN_THREE_SHUTDOWN] = outgen_three_shutdown_i;
      cc_events[PIE_COMPARATOR_EIGHT]      = comparator_eight_i;
      cc_events[PIE_COMPARATOR_SEVEN]      = comparator_seven_i;
      cc_events[PIE_COMPARATOR_SIX]        = comparator_six_i;
      cc_events[PIE_COMPARATOR_FIVE]       = comparator_five_i;
   end

   // write-one-to-clear of request flags
   assign tmr_clear = (wr && hit(adr_i, PIE_OFS_FLAGS_TMR)) ? wbyte : 8'h00;
   assign cc_clear  = (wr && hit(adr_i, PIE_OFS_FLAGS_CC)) ? wbyte : 8'h00;

   // ----------------------------------------------------------------
   // request flags and gating
   // ----------------------------------------------------------------
   pie_flag_bank #(
      .IMPL (TMR_MASK)
   ) u_tmr_flags (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .event_i  (tmr_events),
      .clear_i  (tmr_clear),
      .enable_i (periph_irq_enable_timers_q),
      .flag_o   (tmr_flags),
      .gated_o  (tmr_gated)
   );

   pie_flag_bank #(
      .IMPL (CC_MASK)
   ) u_cc_flags (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .event_i  (cc_events),
      .clear_i  (cc_clear),
      .enable_i (periph_irq_enable_capture_cmp_q),
      .flag_o   (cc_flags),
      .gated_o  (cc_gated)
   );

   // ----------------------------------------------------------------
   // combined request
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= peripheral_master_en_q & (|{tmr_gated, cc_gated});
      end
   end

   assign periph_irq_o = irq_q;

   // ----------------------------------------------------------------
   // read data
   // ----------------------------------------------------------------
   always_comb begin
      rdata = 32'h0000_0000;
      unique case (adr_i)
         PIE_OFS_TIMERS:    rdata[7:0] = periph_irq_enable_timers_q;
         PIE_OFS_CAPCMP:    rdata[7:0] = periph_irq_enable_capture_cmp_q;
         PIE_OFS_FLAGS_TMR: rdata[7:0] = tmr_flags;
         PIE_OFS_FLAGS_CC:  rdata[7:0] = cc_flags;
         PIE_OFS_CTRL:      rdata[PIE_CTRL_PERIPH_EN] = peripheral_master_en_q;
         PIE_OFS_STATUS:    rdata[PIE_STAT_REQUEST] = irq_q;
         default:           rdata = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         dat_o <= 32'h0000_0000;
      end else if (access) begin
         dat_o <= rdata;
      end
   end

endmodule : pie_irq_enable

// file: verification/pie_irq_enable_properties.sv
// checker for pie_irq_enable: bus handshake, read masks, request output
// assumes a master that holds its request until ack
`timescale 1ns/100ps

module pie_irq_enable_chk
   import pie_pkg::*;
#(
   parameter bit LARGE_VARIANT = 1'b1
) (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // bus
   input  wire logic        cyc_i,
   input  wire logic        stb_i,
   input  wire logic        we_i,
   input  wire logic [7:0]  adr_i,
   input  wire logic [3:0]  sel_i,
   input  wire logic [31:0] dat_i,
   input  wire logic [31:0] dat_o,
   input  wire logic        ack_o,
   // request
   input  wire logic        periph_irq_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   property p_ack_after_req; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
   a_ack_after_req: assert property (p_ack_after_req)
      else $error("no ack after request");
   property p_ack_single; ack_o |=> !ack_o; endproperty
   a_ack_single: assert property (p_ack_single)
      else $error("ack longer than one cycle");
   property p_ack_cause; ack_o |-> $past(cyc_i && stb_i); endproperty
   a_ack_cause: assert property (p_ack_cause)
      else $error("ack without request");
   property p_top_zero; ack_o && !we_i && adr_i == PIE_OFS_TIMERS |-> !dat_o[7]; endproperty
   a_top_zero: assert property (p_top_zero)
      else $error("timer bank bit 7 read as one");
   property p_upper_zero; ack_o |-> dat_o[31:8] == 24'h000000; endproperty
   a_upper_zero: assert property (p_upper_zero)
      else $error("read data upper bits set");
   property p_reset_clear;
      disable iff (1'b0) rst_i |=> !ack_o && !periph_irq_o && dat_o == 32'h00000000;
   endproperty
   a_reset_clear: assert property (p_reset_clear)
      else $error("outputs not cleared by reset");
   property p_fall_cause;
      $fell(periph_irq_o) |-> $past(cyc_i && we_i, 1) || $past(cyc_i && we_i, 2) || $past(rst_i);
   endproperty
   a_fall_cause: assert property (p_fall_cause)
      else $error("request dropped without software action");
   property p_small_mask;
      !LARGE_VARIANT && ack_o && !we_i && adr_i == PIE_OFS_CAPCMP
         |-> (dat_o[7:0] & PIE_CAPCMP_LARGE) == 8'h00;
   endproperty
   a_small_mask: assert property (p_small_mask)
      else $error("removed enable bit read as one");
   property p_master_off;
      cyc_i && stb_i && we_i && !ack_o && sel_i[0] && adr_i == PIE_OFS_CTRL && !dat_i[0]
         |=> ##1 !periph_irq_o;
   endproperty
   a_master_off: assert property (p_master_off)
      else $error("request without master enable");

   c_irq_up: cover property ($rose(periph_irq_o));
   c_write: cover property (ack_o && we_i);
   c_status: cover property (ack_o && !we_i && adr_i == PIE_OFS_STATUS);
endmodule : pie_irq_enable_chk

bind pie_irq_enable pie_irq_enable_chk #(.LARGE_VARIANT(LARGE_VARIANT)) u_chk (.*);

// file: verification/pie_src_model.sv
// pie_src_model: timer, capture/compare and comparator event sources
// assumes one bench request bit per source, turned into a one-cycle pulse
`timescale 1ns/100ps

module pie_src_model (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // bench requests
   input  wire logic [14:0] fire_i,
   // event pulses
   output logic      [14:0] event_o
);
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         event_o <= 15'h0000;
      end else begin
         event_o <= fire_i & ~event_o;
      end
   end
endmodule : pie_src_model

// file: verification/tb_periph_irq_enable_banks_4_5.sv
// testbench: large and small variant on one wishbone master and source model
// assumes the package register map and a one-wait-state slave
`timescale 1ns/100ps

module tb_periph_irq_enable_banks_4_5 import pie_pkg::*;;
   logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, periph_irq_o, irq_s;
   logic [7:0]  adr_i;
   logic [3:0]  sel_i;
   logic [31:0] dat_i, dat_o, dat_s, q, qs;
   logic [14:0] fire, ev;
   logic        timer_eight_match_i, timer_five_gate_i, timer_five_event_i;
   logic        timer_three_gate_i, timer_three_event_i, timer_six_match_i;
   logic        timer_four_match_i, capcmp_eight_i, capcmp_seven_i, comparator_five_i;
   logic        outgen_four_shutdown_i, outgen_three_shutdown_i, comparator_eight_i;
   logic        comparator_seven_i, comparator_six_i;
   int          mismatches, checked;

   assign {capcmp_eight_i, capcmp_seven_i, outgen_four_shutdown_i, outgen_three_shutdown_i,
           comparator_eight_i, comparator_seven_i, comparator_six_i, comparator_five_i,
           timer_eight_match_i, timer_five_gate_i, timer_five_event_i, timer_three_gate_i,
           timer_three_event_i, timer_six_match_i, timer_four_match_i} = ev;

   pie_src_model u_src (.clk_i(clk_i), .rst_i(rst_i), .fire_i(fire), .event_o(ev));
   pie_irq_enable u_dut (.*);
   pie_irq_enable #(.LARGE_VARIANT(1'b0)) u_small (.*, .dat_o(dat_s), .ack_o(),
                                                   .periph_irq_o(irq_s));

   initial begin
      clk_i = 1'b0;
      forever #12.5 clk_i = ~clk_i;
   end

   task automatic conclude();
      if (mismatches == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : conclude

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      checked++;
      if (s !== e) begin
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
         mismatches++;
      end
   endtask : chk

   // one classic cycle; data taken at the edge that samples ack
   task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= a;
      dat_i <= {24'h000000, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 20);
      chk("ack", 32'h1, {31'h0, ack_o});
      q = dat_o;
      qs = dat_s;
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i <= 1'b0;
   endtask : acc

   task automatic t_reset();
      for (int i = 0; i < 7; i++) begin
         acc(1'b0, 8'(i * 4), 8'h00);
         chk("reset read", 32'h0, q);
      end
   endtask : t_reset

   task automatic t_rw();
      acc(1'b1, PIE_OFS_TIMERS, 8'hff);
      acc(1'b0, PIE_OFS_TIMERS, 8'h00);
      chk("timers rw", {24'h0, PIE_TIMERS_IMPL}, q);
      acc(1'b1, PIE_OFS_CAPCMP, 8'hff);
      acc(1'b0, PIE_OFS_CAPCMP, 8'h00);
      chk("capcmp rw", {24'h0, PIE_CAPCMP_IMPL}, q);
      chk("capcmp small", {24'h0, ~PIE_CAPCMP_LARGE}, qs);
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      acc(1'b0, PIE_OFS_CAPCMP, 8'h00);
      chk("capcmp after reset", 32'h0, q);
      acc(1'b0, PIE_OFS_TIMERS, 8'h00);
      chk("timers after reset", 32'h0, q);
   endtask : t_rw

   // ignored writes, control readback, event meeting its own clear
   task automatic t_edge();
      acc(1'b1, PIE_OFS_TIMERS, 8'h55);
      sel_i <= 4'he;
      acc(1'b1, PIE_OFS_TIMERS, 8'h2a);
      sel_i <= 4'hf;
      acc(1'b1, 8'h18, 8'hff);
      acc(1'b1, PIE_OFS_STATUS, 8'hff);
      acc(1'b0, PIE_OFS_TIMERS, 8'h00);
      chk("lane 0 off", 32'h55, q);
      acc(1'b0, 8'h18, 8'h00);
      chk("unmapped", 32'h0, q);
      acc(1'b0, PIE_OFS_STATUS, 8'h00);
      chk("status ro", 32'h0, q);
      acc(1'b1, PIE_OFS_CTRL, 8'h01);
      acc(1'b0, PIE_OFS_CTRL, 8'h00);
      chk("master rw", 32'h1, q);
      // event pulse lands on the same edge as its clear
      fire <= 15'h0001;
      fork
         acc(1'b1, PIE_OFS_FLAGS_TMR, 8'hff);
         begin
            @(posedge clk_i);
            fire <= 15'h0000;
         end
      join
      acc(1'b0, PIE_OFS_FLAGS_TMR, 8'h00);
      chk("set over clear", 32'h1, q);
      chk("irq", 32'h1, {31'h0, periph_irq_o});
      acc(1'b1, PIE_OFS_CTRL, 8'h00);
      acc(1'b1, PIE_OFS_TIMERS, 8'h00);
   endtask : t_edge

   // one source: flagged while blocked, passed, master-gated, disabled
   task automatic t_src(input int i);
      logic [7:0] a, fa, m;
      logic       keep;
      a = (i < 7) ? PIE_OFS_TIMERS : PIE_OFS_CAPCMP;
      fa = (i < 7) ? PIE_OFS_FLAGS_TMR : PIE_OFS_FLAGS_CC;
      m = 8'h01 << ((i < 7) ? i : i - 7);
      keep = (i < 7) || ((m & PIE_CAPCMP_LARGE) == 8'h00);
      acc(1'b1, fa, 8'hff);
      acc(1'b1, PIE_OFS_CTRL, 8'h01);
      @(posedge clk_i);
      fire <= 15'h0001 << i;
      @(posedge clk_i);
      fire <= 15'h0000;
      repeat (3) @(posedge clk_i);
      acc(1'b0, fa, 8'h00);
      chk("flag", {24'h0, m}, q);
      chk("blocked", 32'h0, {31'h0, periph_irq_o});
      acc(1'b1, a, m);
      repeat (3) @(posedge clk_i);
      chk("passed", 32'h1, {31'h0, periph_irq_o});
      chk("small", {31'h0, keep}, {31'h0, irq_s});
      acc(1'b0, PIE_OFS_STATUS, 8'h00);
      chk("status", 32'h1, q);
      acc(1'b1, PIE_OFS_CTRL, 8'h00);
      repeat (3) @(posedge clk_i);
      chk("master off", 32'h0, {31'h0, periph_irq_o});
      acc(1'b1, a, 8'h00);
   endtask : t_src

   task automatic t_gate();
      t_src(0);
      t_src(1);
      t_src(2);
      t_src(3);
      t_src(4);
      t_src(5);
      t_src(6);
      t_src(7);
      t_src(8);
      t_src(9);
      t_src(10);
      t_src(11);
      t_src(12);
      t_src(13);
      t_src(14);
   endtask : t_gate

   initial begin
      rst_i = 1'b1;
      cyc_i = 1'b0;
      stb_i = 1'b0;
      we_i = 1'b0;
      adr_i = 8'h00;
      sel_i = 4'hf;
      dat_i = 32'h00000000;
      fire = 15'h0000;
      mismatches = 0;
      checked = 0;
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      t_reset();
      t_rw();
      t_edge();
      t_gate();
      conclude();
   end

   initial begin
      repeat (6000) @(posedge clk_i);
      mismatches++;
      conclude();
   end
endmodule : tb_periph_irq_enable_banks_4_5
